// ==== hw/rsi_top.sv ====
// Contract
// - Internal reset when external reset pin or watchdog reset request is asserted.
// - Shift and slave address registers hold in standby reset, clear to 00 on reset in operation.
// - Serial mode and serial bus control registers clear on any reset.
// - CPU clock, system clock, clock out, sub-oscillator control clear on reset.
// - Display mode, display control, display/port select clear on reset.
// - All interrupt request flags clear on reset.
// - Interrupt enables, priority select, three edge mode registers clear.
// - Port output buffers off and output latches cleared on reset.
// - Port direction and pull-up registers clear on reset.
// - After reset wait 2^17 or 2^15 oscillator cycles, chosen at build.
`timescale 1ns/1ps
module rsi_top
  import rsi_pkg::*;
#(
  parameter bit          LONG_WAIT = 1'b1,
  parameter int unsigned WAIT_LONG  = RSI_WAIT_LONG_CYC,
  parameter int unsigned WAIT_SHORT = RSI_WAIT_SHORT_CYC,
  parameter int unsigned NIRQ       = 10
) (
  // Clock and reset
  input  wire logic            SYS_CLK,
  input  wire logic            RST,
  input  wire logic            CE,
  // Reset sources and standby state (asynchronous)
  input  wire logic            RESET_PIN,
  input  wire logic            WDT_RESET_REQ,
  input  wire logic            STOP_ACTIVE,
  input  wire logic            HALT_ACTIVE,
  // Core register writes and interrupt sources
  input  wire rsi_wr_t         REG_WR,
  input  wire logic [NIRQ-1:0] IRQ_SET,
  // Status
  output logic                 INT_RESET,
  output logic                 CPU_RUN,
  output logic                 STANDBY_RESET,
  // Register contents
  output logic [7:0]           SERIAL_SHIFT_REG,
  output logic [7:0]           SERIAL_SLAVE_ADDR_REG,
  output logic [7:0]           SERIAL_OP_MODE_REG,
  output logic [7:0]           SERIAL_BUS_CTRL_REG,
  output logic [3:0]           CPU_CLOCK_CTRL_REG,
  output logic [3:0]           SYSTEM_CLOCK_CTRL_REG,
  output logic [3:0]           CLOCK_OUT_MODE_REG,
  output logic [3:0]           SUB_OSC_CTRL_REG,
  output logic [3:0]           DISPLAY_MODE_REG,
  output logic [3:0]           DISPLAY_CTRL_REG,
  output logic [3:0]           DISPLAY_PORT_SELECT_REG,
  output logic [NIRQ-1:0]      IRQ_REQUEST_FLAGS,
  output logic [NIRQ-1:0]      IRQ_ENABLE_FLAGS,
  output logic [3:0]           IRQ_PRIORITY_SELECT_REG,
  output logic [3:0]           EXT_IRQ0_EDGE_MODE,
  output logic [3:0]           EXT_IRQ1_EDGE_MODE,
  output logic [3:0]           EXT_IRQ2_EDGE_MODE,
  output logic [7:0]           PORT_OUT_LATCH,
  output logic [7:0]           PORT_OUT_EN_N,
  output logic [7:0]           PORT_DIRECTION_REGS,
  output logic [7:0]           PORT_PULLUP_REGS
);

  localparam logic [RSI_WAIT_W-1:0] WAIT_CYC =
    LONG_WAIT ? RSI_WAIT_W'(WAIT_LONG - 1) : RSI_WAIT_W'(WAIT_SHORT - 1);

  logic [3:0]            sync1_q;
  logic [3:0]            sync2_q;
  logic                  rst_any;
  logic                  ireset;
  logic                  standby_now;
  logic [RSI_WAIT_W-1:0] wait_q;
  rsi_state_t            state_q;

  function automatic logic hit(input rsi_wr_t w, input logic [4:0] s);
    return w.wr && (w.sel == s);
  endfunction

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else if (CE) begin
      sync1_q <= {HALT_ACTIVE, STOP_ACTIVE, WDT_RESET_REQ, RESET_PIN};
      sync2_q <= sync1_q;
    end
  end

  assign rst_any = sync2_q[0] | sync2_q[1];
  assign ireset  = RST | rst_any;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      INT_RESET <= 1'b1;
    end else if (CE) begin
      INT_RESET <= rst_any;
    end
  end

  assign standby_now = sync2_q[2] | sync2_q[3];

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      STANDBY_RESET <= 1'b0;
    end else if (CE && rst_any && state_q == RSI_ST_RUN) begin
      STANDBY_RESET <= standby_now;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (ireset) begin
      state_q <= RSI_ST_WAIT;
      wait_q  <= WAIT_CYC;
      CPU_RUN <= 1'b0;
    end else if (CE) begin
      case (state_q)
        RSI_ST_WAIT: begin
          if (wait_q == '0) begin
            state_q <= RSI_ST_RUN;
            CPU_RUN <= 1'b1;
          end else begin
            wait_q <= wait_q - 1'b1;
          end
        end
        default: begin
          state_q <= RSI_ST_RUN;
          CPU_RUN <= 1'b1;
        end
      endcase
    end
  end

  // held after standby, dropped after reset in operation
  always_ff @(posedge SYS_CLK) begin
    if (CE && rst_any && state_q == RSI_ST_RUN && !standby_now) begin
      SERIAL_SHIFT_REG      <= RSI_BYTE_RST;
      SERIAL_SLAVE_ADDR_REG <= RSI_BYTE_RST;
    end else if (CE && !ireset) begin
      if (hit(REG_WR, RSI_SEL_SHIFT)) SERIAL_SHIFT_REG <= REG_WR.data;
      if (hit(REG_WR, RSI_SEL_SADDR)) SERIAL_SLAVE_ADDR_REG <= REG_WR.data;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (ireset) begin
      SERIAL_OP_MODE_REG  <= RSI_BYTE_RST;
      SERIAL_BUS_CTRL_REG <= RSI_BYTE_RST;
    end else if (CE) begin
      if (hit(REG_WR, RSI_SEL_SMODE)) SERIAL_OP_MODE_REG <= REG_WR.data;
      if (hit(REG_WR, RSI_SEL_SBUS)) SERIAL_BUS_CTRL_REG <= REG_WR.data;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (ireset) begin
      CPU_CLOCK_CTRL_REG    <= RSI_NIB_RST;
      SYSTEM_CLOCK_CTRL_REG <= RSI_NIB_RST;
      CLOCK_OUT_MODE_REG    <= RSI_NIB_RST;
      SUB_OSC_CTRL_REG      <= RSI_NIB_RST;
    end else if (CE) begin
      if (hit(REG_WR, RSI_SEL_CPUCLK)) CPU_CLOCK_CTRL_REG <= REG_WR.data[3:0];
      if (hit(REG_WR, RSI_SEL_SYSCLK)) SYSTEM_CLOCK_CTRL_REG <= REG_WR.data[3:0];
      if (hit(REG_WR, RSI_SEL_CLKOUT)) CLOCK_OUT_MODE_REG <= REG_WR.data[3:0];
      if (hit(REG_WR, RSI_SEL_SUBOSC)) SUB_OSC_CTRL_REG <= REG_WR.data[3:0];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (ireset) begin
      DISPLAY_MODE_REG        <= RSI_NIB_RST;
      DISPLAY_CTRL_REG        <= RSI_NIB_RST;
      DISPLAY_PORT_SELECT_REG <= RSI_NIB_RST;
    end else if (CE) begin
      if (hit(REG_WR, RSI_SEL_DMODE)) DISPLAY_MODE_REG <= REG_WR.data[3:0];
      if (hit(REG_WR, RSI_SEL_DCTRL)) DISPLAY_CTRL_REG <= REG_WR.data[3:0];
      if (hit(REG_WR, RSI_SEL_DPSEL)) DISPLAY_PORT_SELECT_REG <= REG_WR.data[3:0];
    end
  end

  // request flags, set wins over clear
  always_ff @(posedge SYS_CLK) begin
    if (ireset) begin
      IRQ_REQUEST_FLAGS <= '0;
    end else if (CE) begin
      if (hit(REG_WR, RSI_SEL_IRQCLR)) begin
        IRQ_REQUEST_FLAGS <= (IRQ_REQUEST_FLAGS & ~NIRQ'(REG_WR.data)) | IRQ_SET;
      end else begin
        IRQ_REQUEST_FLAGS <= IRQ_REQUEST_FLAGS | IRQ_SET;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (ireset) begin
      IRQ_ENABLE_FLAGS        <= '0;
      IRQ_PRIORITY_SELECT_REG <= RSI_NIB_RST;
      EXT_IRQ0_EDGE_MODE      <= RSI_NIB_RST;
      EXT_IRQ1_EDGE_MODE      <= RSI_NIB_RST;
      EXT_IRQ2_EDGE_MODE      <= RSI_NIB_RST;
    end else if (CE) begin
      if (hit(REG_WR, RSI_SEL_IRQEN)) IRQ_ENABLE_FLAGS <= NIRQ'(REG_WR.data);
      if (hit(REG_WR, RSI_SEL_IPRIO)) IRQ_PRIORITY_SELECT_REG <= REG_WR.data[3:0];
      if (hit(REG_WR, RSI_SEL_IM0)) EXT_IRQ0_EDGE_MODE <= REG_WR.data[3:0];
      if (hit(REG_WR, RSI_SEL_IM1)) EXT_IRQ1_EDGE_MODE <= REG_WR.data[3:0];
      if (hit(REG_WR, RSI_SEL_IM2)) EXT_IRQ2_EDGE_MODE <= REG_WR.data[3:0];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (ireset) begin
      PORT_OUT_LATCH      <= RSI_BYTE_RST;
      PORT_OUT_EN_N       <= RSI_OUT_OFF;
      PORT_DIRECTION_REGS <= RSI_BYTE_RST;
      PORT_PULLUP_REGS    <= RSI_BYTE_RST;
    end else if (CE) begin
      if (hit(REG_WR, RSI_SEL_PLAT)) PORT_OUT_LATCH <= REG_WR.data;
      if (hit(REG_WR, RSI_SEL_PDIR)) begin
        PORT_DIRECTION_REGS <= REG_WR.data;
        PORT_OUT_EN_N       <= ~REG_WR.data;
      end
      if (hit(REG_WR, RSI_SEL_PPU)) PORT_PULLUP_REGS <= REG_WR.data;
    end
  end

endmodule

// ==== inc/rsi_pkg.sv ====
package rsi_pkg;

  // Wait counts in main oscillator cycles, selected at build time
  localparam int unsigned RSI_WAIT_LONG_CYC  = 131072;
  localparam int unsigned RSI_WAIT_SHORT_CYC = 32768;
  localparam int unsigned RSI_WAIT_W         = 18;

  // Reset values
  localparam logic [3:0] RSI_NIB_RST  = 4'h0;
  localparam logic [7:0] RSI_BYTE_RST = 8'h00;
  localparam logic [7:0] RSI_OUT_OFF  = 8'hff;

  typedef enum logic [1:0] {
    RSI_ST_RUN  = 2'b00,
    RSI_ST_WAIT = 2'b01
  } rsi_state_t;

  // Register writes from the core
  typedef struct packed {
    logic       wr;
    logic [4:0] sel;
    logic [7:0] data;
  } rsi_wr_t;

  localparam logic [4:0] RSI_SEL_SHIFT  = 5'h00;
  localparam logic [4:0] RSI_SEL_SADDR  = 5'h01;
  localparam logic [4:0] RSI_SEL_SMODE  = 5'h02;
  localparam logic [4:0] RSI_SEL_SBUS   = 5'h03;
  localparam logic [4:0] RSI_SEL_CPUCLK = 5'h04;
  localparam logic [4:0] RSI_SEL_SYSCLK = 5'h05;
  localparam logic [4:0] RSI_SEL_CLKOUT = 5'h06;
  localparam logic [4:0] RSI_SEL_SUBOSC = 5'h07;
  localparam logic [4:0] RSI_SEL_DMODE  = 5'h08;
  localparam logic [4:0] RSI_SEL_DCTRL  = 5'h09;
  localparam logic [4:0] RSI_SEL_DPSEL  = 5'h0a;
  localparam logic [4:0] RSI_SEL_IRQEN  = 5'h0b;
  localparam logic [4:0] RSI_SEL_IPRIO  = 5'h0c;
  localparam logic [4:0] RSI_SEL_IM0    = 5'h0d;
  localparam logic [4:0] RSI_SEL_IM1    = 5'h0e;
  localparam logic [4:0] RSI_SEL_IM2    = 5'h0f;
  localparam logic [4:0] RSI_SEL_PLAT   = 5'h10;
  localparam logic [4:0] RSI_SEL_PDIR   = 5'h11;
  localparam logic [4:0] RSI_SEL_PPU    = 5'h12;
  localparam logic [4:0] RSI_SEL_IRQCLR = 5'h13;

endpackage

// ==== verification/rsi_asserts.sv ====
`timescale 1ns/1ps
module rsi_asserts #(
  parameter int NIRQ = 10,
  parameter int WAIT = 8
) (
  // Clock, reset and reset sources
  input logic            SYS_CLK,
  input logic            RST,
  input logic            RESET_PIN,
  input logic            WDT_RESET_REQ,
  // Status
  input logic            INT_RESET,
  input logic            CPU_RUN,
  // Registers cleared by every reset, PORT_OUT_EN_N set to ff
  input logic [7:0]      SERIAL_OP_MODE_REG,
  input logic [7:0]      SERIAL_BUS_CTRL_REG,
  input logic [3:0]      CPU_CLOCK_CTRL_REG,
  input logic [3:0]      SYSTEM_CLOCK_CTRL_REG,
  input logic [3:0]      CLOCK_OUT_MODE_REG,
  input logic [3:0]      SUB_OSC_CTRL_REG,
  input logic [3:0]      DISPLAY_MODE_REG,
  input logic [3:0]      DISPLAY_CTRL_REG,
  input logic [3:0]      DISPLAY_PORT_SELECT_REG,
  input logic [NIRQ-1:0] IRQ_REQUEST_FLAGS,
  input logic [NIRQ-1:0] IRQ_ENABLE_FLAGS,
  input logic [3:0]      IRQ_PRIORITY_SELECT_REG,
  input logic [3:0]      EXT_IRQ0_EDGE_MODE,
  input logic [3:0]      EXT_IRQ1_EDGE_MODE,
  input logic [3:0]      EXT_IRQ2_EDGE_MODE,
  input logic [7:0]      PORT_OUT_LATCH,
  input logic [7:0]      PORT_OUT_EN_N,
  input logic [7:0]      PORT_DIRECTION_REGS,
  input logic [7:0]      PORT_PULLUP_REGS
);
  // Status drops one cycle after the internal reset does
  localparam int LO = WAIT - 1;
  localparam int HI = WAIT - 1;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  property p_merge; (RESET_PIN || WDT_RESET_REQ) [*4] |-> INT_RESET; endproperty
  a_merge: assert property (p_merge) else $error("reset source not merged");
  property p_serial; INT_RESET [*2] |-> (SERIAL_OP_MODE_REG | SERIAL_BUS_CTRL_REG) == 8'h00;
  endproperty
  a_serial: assert property (p_serial) else $error("serial regs not cleared");
  property p_clock; INT_RESET [*2] |-> (CPU_CLOCK_CTRL_REG | SYSTEM_CLOCK_CTRL_REG
    | CLOCK_OUT_MODE_REG | SUB_OSC_CTRL_REG) == 4'h0; endproperty
  a_clock: assert property (p_clock) else $error("clock regs not cleared");
  property p_disp; INT_RESET [*2] |->
    (DISPLAY_MODE_REG | DISPLAY_CTRL_REG | DISPLAY_PORT_SELECT_REG) == 4'h0; endproperty
  a_disp: assert property (p_disp) else $error("display regs not cleared");
  property p_irq; INT_RESET [*2] |-> IRQ_REQUEST_FLAGS == '0; endproperty
  a_irq: assert property (p_irq) else $error("request flags not cleared");
  property p_icfg; INT_RESET [*2] |-> IRQ_ENABLE_FLAGS == '0 && (IRQ_PRIORITY_SELECT_REG
    | EXT_IRQ0_EDGE_MODE | EXT_IRQ1_EDGE_MODE | EXT_IRQ2_EDGE_MODE) == 4'h0; endproperty
  a_icfg: assert property (p_icfg) else $error("irq config not cleared");
  property p_port; INT_RESET [*2] |-> PORT_OUT_LATCH == 8'h00 && PORT_OUT_EN_N == 8'hff
    && (PORT_DIRECTION_REGS | PORT_PULLUP_REGS) == 8'h00; endproperty
  a_port: assert property (p_port) else $error("port state not cleared");
  property p_hold; INT_RESET [*2] |-> !CPU_RUN; endproperty
  a_hold: assert property (p_hold) else $error("running during reset");
  property p_run; $fell(INT_RESET) |-> ##[LO:HI] $rose(CPU_RUN); endproperty
  a_run: assert property (p_run) else $error("settling wait wrong");
endmodule
bind rsi_top rsi_asserts #(.NIRQ(NIRQ), .WAIT(LONG_WAIT ? WAIT_LONG : WAIT_SHORT)) u_chk (.*);

// ==== verification/rsi_tb_top.sv ====
`timescale 1ns/1ps
module rsi_tb_top;
  import rsi_pkg::*;
  localparam int W = 8;
  logic SYS_CLK = 0, RST = 1, CE = 1, RESET_PIN = 0, WDT_RESET_REQ = 0;
  logic STOP_ACTIVE = 0, HALT_ACTIVE = 0, INT_RESET, CPU_RUN, STANDBY_RESET;
  rsi_wr_t REG_WR = '0;
  logic [9:0] IRQ_SET = '0, IRQ_REQUEST_FLAGS, IRQ_ENABLE_FLAGS;
  logic [7:0] SERIAL_SHIFT_REG, SERIAL_SLAVE_ADDR_REG, SERIAL_OP_MODE_REG, SERIAL_BUS_CTRL_REG;
  logic [7:0] PORT_OUT_LATCH, PORT_OUT_EN_N, PORT_DIRECTION_REGS, PORT_PULLUP_REGS;
  logic [3:0] CPU_CLOCK_CTRL_REG, SYSTEM_CLOCK_CTRL_REG, CLOCK_OUT_MODE_REG, SUB_OSC_CTRL_REG;
  logic [3:0] DISPLAY_MODE_REG, DISPLAY_CTRL_REG, DISPLAY_PORT_SELECT_REG;
  logic [3:0] IRQ_PRIORITY_SELECT_REG, EXT_IRQ0_EDGE_MODE, EXT_IRQ1_EDGE_MODE, EXT_IRQ2_EDGE_MODE;
  int fails = 0, n_tests = 0;
  rsi_top #(.LONG_WAIT(1'b1), .WAIT_LONG(W), .WAIT_SHORT(4)) dut (.*);
  always #4 SYS_CLK = ~SYS_CLK;
  task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] sel, input logic [7:0] d);
    @(negedge SYS_CLK);
    REG_WR = '{1'b1, sel, d};
    @(negedge SYS_CLK);
    REG_WR = '0;
  endtask
  // Counts cycles from the status drop, one cycle after the internal reset
  task automatic run_wait();
    int n;
    n = 0;
    while (INT_RESET !== 1'b0 && n < 20) begin
      @(negedge SYS_CLK);
      n++;
    end
    n = 0;
    while (CPU_RUN !== 1'b1 && n < 40) begin
      @(negedge SYS_CLK);
      n++;
    end
    chk("wait", n, W - 1);
  endtask
  // Cleared registers against written or reset values
  task automatic chk_regs(input logic wrote);
    logic [7:0] b;
    logic [7:0] nb;
    logic [3:0] q;
    b = wrote ? 8'ha5 : RSI_BYTE_RST;
    nb = ~b;
    q = wrote ? 4'h5 : RSI_NIB_RST;
    chk("smode", SERIAL_OP_MODE_REG, b);
    chk("sbus", SERIAL_BUS_CTRL_REG, b);
    chk("cpuclk", CPU_CLOCK_CTRL_REG, q);
    chk("sysclk", SYSTEM_CLOCK_CTRL_REG, q);
    chk("clkout", CLOCK_OUT_MODE_REG, q);
    chk("subosc", SUB_OSC_CTRL_REG, q);
    chk("dmode", DISPLAY_MODE_REG, q);
    chk("dctrl", DISPLAY_CTRL_REG, q);
    chk("dpsel", DISPLAY_PORT_SELECT_REG, q);
    chk("irqen", IRQ_ENABLE_FLAGS, {2'h0, b});
    chk("iprio", IRQ_PRIORITY_SELECT_REG, q);
    chk("im0", EXT_IRQ0_EDGE_MODE, q);
    chk("im1", EXT_IRQ1_EDGE_MODE, q);
    chk("im2", EXT_IRQ2_EDGE_MODE, q);
    chk("plat", PORT_OUT_LATCH, b);
    chk("en_n_w", PORT_OUT_EN_N, nb);
    chk("pdir", PORT_DIRECTION_REGS, b);
    chk("ppu", PORT_PULLUP_REGS, b);
  endtask
  task automatic rst_in(input logic wd, input logic [1:0] sb);
    @(negedge SYS_CLK);
    {STOP_ACTIVE, HALT_ACTIVE} = sb;
    repeat (3) @(negedge SYS_CLK);
    if (wd) WDT_RESET_REQ = 1'b1;
    else RESET_PIN = 1'b1;
    repeat (6) @(negedge SYS_CLK);
    {RESET_PIN, WDT_RESET_REQ, STOP_ACTIVE, HALT_ACTIVE} = '0;
    run_wait();
    chk("standby", STANDBY_RESET, |sb);
    if (sb != 2'b00) chk("shift", SERIAL_SHIFT_REG, 8'ha5);
    if (sb != 2'b00) chk("saddr", SERIAL_SLAVE_ADDR_REG, 8'ha5);
    if (sb == 2'b00) chk("shift_op", SERIAL_SHIFT_REG, RSI_BYTE_RST);
    if (sb == 2'b00) chk("saddr_op", SERIAL_SLAVE_ADDR_REG, RSI_BYTE_RST);
    chk("en_n", PORT_OUT_EN_N, 8'hff);
    chk("irq_rst", IRQ_REQUEST_FLAGS, 10'h000);
    chk_regs(1'b0);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard
  initial begin
    #20000;
    fails++;
    summarize();
  end
  initial begin
    repeat (6) @(negedge SYS_CLK);
    RST = 1'b0;
    run_wait();
    // Plain reset, watchdog in halt, pin in stop
    for (int i = 0; i < 3; i++) begin
      for (int s = 0; s < 19; s++) wr(s[4:0], 8'ha5);
      @(negedge SYS_CLK);
      IRQ_SET = '1;
      @(negedge SYS_CLK);
      // Clear and set of one flag in one cycle: the set wins
      IRQ_SET = 10'h001;
      REG_WR = '{1'b1, RSI_SEL_IRQCLR, 8'h0f};
      chk("irq_set", IRQ_REQUEST_FLAGS, 10'h3ff);
      chk("cpuclk", CPU_CLOCK_CTRL_REG, 10'h005);
      chk_regs(1'b1);
      @(negedge SYS_CLK);
      IRQ_SET = '0;
      REG_WR = '0;
      chk("irq_clr", IRQ_REQUEST_FLAGS, 10'h3f1);
      rst_in(i == 1, i[1:0]);
      $display("test %0d done", i);
    end
    summarize();
  end
endmodule
